/* verilog/dxb_pkg.sv */
package dxb_pkg;

  // ------------------------------------------------------------
  // widths and reset timing
  // ------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int PORT_W = 3;
  localparam int DATA_W = 16;
  localparam int RESET_MIN_CYCLES = 5;
  localparam logic [2:0] RESET_CNT_INIT = 3'h0;
  localparam logic [11:0] ADDR_RESET = 12'h000;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // ------------------------------------------------------------
  // bus cycle kinds requested by the core
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    DXB_CYC_FETCH,
    DXB_CYC_PORT_IN,
    DXB_CYC_PORT_OUT,
    DXB_CYC_TABLE_WRITE_OP_SECOND,
    DXB_CYC_OTHER
  } dxb_cycle_type;

endpackage : dxb_pkg

/* verilog/dxb_bus_pins.sv */
module dxb_bus_pins
  import dxb_pkg::*;
#(
  parameter int RESET_HOLD = RESET_MIN_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // core side, one entry per machine cycle
  input wire logic cyc_valid,
  input wire dxb_cycle_type cyc_kind,
  input wire logic [ADDR_W-1:0] cyc_pc,
  input wire logic [PORT_W-1:0] cyc_port,
  input wire logic [DATA_W-1:0] cyc_wdata,
  output logic [DATA_W-1:0] core_rdata,
  output logic core_in_reset,
  // external pins
  output logic [ADDR_W-1:0] program_address_lines,
  output logic [DATA_W-1:0] parallel_data_lines_o,
  output logic [DATA_W-1:0] parallel_data_lines_oe_n,
  input wire logic [DATA_W-1:0] parallel_data_lines_i,
  output logic input_strobe_n,
  output logic write_strobe_n,
  output logic fetch_strobe_n
);

  // ------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------
  // the hold counter is three bits wide and must end above zero
  if (RESET_HOLD < 1 || RESET_HOLD > 7) begin : g_bad_hold
    $error("RESET_HOLD must be 1..7");
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0] rst_cnt;
    logic [DATA_W-1:0] dout;
    logic [DATA_W-1:0] oe_n;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] din_s1;
    logic [DATA_W-1:0] din_s2;
    logic in_n;
    logic wr_n;
    logic fe_n;
    logic in_reset;
    logic in_p1;
    logic in_p2;
  } dxb_state_type;

  dxb_state_type st_q;
  dxb_state_type st_d;

  // the address has a synchronous clear, so it lives apart from the state
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;

  // ------------------------------------------------------------
  // decoding
  // ------------------------------------------------------------
  // port cycles: selected port on the low lines, upper lines low
  function automatic logic [ADDR_W-1:0] port_addr(input logic [PORT_W-1:0] port);
    return {{(ADDR_W-PORT_W){1'b0}}, port};
  endfunction : port_addr

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    // data lines and the strobe flag travel the same two-flop path
    st_d.din_s1 = parallel_data_lines_i;
    st_d.din_s2 = st_q.din_s1;
    st_d.in_p1 = ~st_q.in_n;
    st_d.in_p2 = st_q.in_p1;
    st_d.in_reset = 1'b0;
    st_d.in_n = 1'b1;
    st_d.wr_n = 1'b1;
    st_d.fe_n = 1'b1;
    st_d.oe_n = {DATA_W{1'b1}};
    // the word seen under the input strobe reaches the core three clocks later
    if (st_q.in_p2) begin
      st_d.rdata = st_q.din_s2;
    end
    if (st_q.rst_cnt != 3'(RESET_HOLD)) begin
      // requests during the hold are dropped without trace
      st_d.rst_cnt = st_q.rst_cnt + 3'h1;
      st_d.in_reset = 1'b1;
      addr_d = ADDR_RESET;
    end else if (cyc_valid) begin
      unique case (cyc_kind)
        DXB_CYC_PORT_IN: begin
          addr_d = port_addr(cyc_port);
          st_d.in_n = 1'b0;
        end
        DXB_CYC_PORT_OUT: begin
          addr_d = port_addr(cyc_port);
          st_d.wr_n = 1'b0;
          st_d.dout = cyc_wdata;
          st_d.oe_n = {DATA_W{1'b0}};
        end
        DXB_CYC_TABLE_WRITE_OP_SECOND: begin
          addr_d = cyc_pc;
          st_d.wr_n = 1'b0;
          st_d.dout = cyc_wdata;
          st_d.oe_n = {DATA_W{1'b0}};
        end
        DXB_CYC_FETCH, DXB_CYC_OTHER: begin
          addr_d = cyc_pc;
          st_d.fe_n = 1'b0;
        end
        // codes outside the enum still fetch, so the strobe never goes missing
        default: begin
          addr_d = cyc_pc;
          st_d.fe_n = 1'b0;
        end
      endcase
    end else begin
      st_d.fe_n = 1'b0;
    end
  end

  // strobes high and bus released as soon as reset falls; address waits a clock
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q.rst_cnt <= RESET_CNT_INIT;
      st_q.dout <= DATA_RESET;
      st_q.oe_n <= {DATA_W{1'b1}};
      st_q.rdata <= DATA_RESET;
      st_q.din_s1 <= DATA_RESET;
      st_q.din_s2 <= DATA_RESET;
      st_q.in_n <= 1'b1;
      st_q.wr_n <= 1'b1;
      st_q.fe_n <= 1'b1;
      st_q.in_reset <= 1'b1;
      st_q.in_p1 <= 1'b0;
      st_q.in_p2 <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // address is cleared synchronously, one clock after reset is seen
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      addr_q <= ADDR_RESET;
    end else begin
      addr_q <= addr_d;
    end
  end

  assign program_address_lines = addr_q;
  assign parallel_data_lines_o = st_q.dout;
  assign parallel_data_lines_oe_n = st_q.oe_n;
  assign input_strobe_n = st_q.in_n;
  assign write_strobe_n = st_q.wr_n;
  assign fetch_strobe_n = st_q.fe_n;
  assign core_rdata = st_q.rdata;
  assign core_in_reset = st_q.in_reset;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_data_drive_wr: assert property (@(posedge clk_sys) disable iff (!nrst)
    (parallel_data_lines_oe_n == {DATA_W{1'b0}}) == !write_strobe_n)
    else $error("data bus drive does not follow write strobe");
  a_in_strobe_excl: assert property (@(posedge clk_sys) disable iff (!nrst)
    !input_strobe_n |-> write_strobe_n && fetch_strobe_n)
    else $error("input strobe overlaps another strobe");
  a_wr_strobe_excl: assert property (@(posedge clk_sys) disable iff (!nrst)
    !write_strobe_n |-> input_strobe_n && fetch_strobe_n)
    else $error("write strobe overlaps another strobe");
  a_fetch_default: assert property (@(posedge clk_sys) disable iff (!nrst)
    (input_strobe_n && write_strobe_n && !core_in_reset) |-> !fetch_strobe_n)
    else $error("fetch strobe missing");
  a_port_upper_low: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!input_strobe_n || (!write_strobe_n && $past(cyc_kind) == DXB_CYC_PORT_OUT))
    |-> program_address_lines[ADDR_W-1:PORT_W] == '0)
    else $error("upper address lines not low in port cycle");
  a_port_select: assert property (@(posedge clk_sys) disable iff (!nrst)
    ($past(cyc_valid) && $past(cyc_kind) == DXB_CYC_PORT_IN && !core_in_reset)
    |-> program_address_lines[PORT_W-1:0] == $past(cyc_port))
    else $error("port number not on select lines");
  a_reset_strobes: assert property (@(posedge clk_sys) disable iff (!nrst)
    core_in_reset |-> input_strobe_n && write_strobe_n && fetch_strobe_n
      && parallel_data_lines_oe_n == {DATA_W{1'b1}})
    else $error("strobes active during reset");
  a_reset_addr: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(nrst) |-> program_address_lines == ADDR_RESET)
    else $error("address not cleared after reset");
  a_addr_fetch: assert property (@(posedge clk_sys) disable iff (!nrst)
    ($past(cyc_valid) && $past(cyc_kind) == DXB_CYC_FETCH && !core_in_reset)
    |-> program_address_lines == $past(cyc_pc))
    else $error("fetch address not driven");
  a_addr_other: assert property (@(posedge clk_sys) disable iff (!nrst)
    ($past(cyc_valid) && !core_in_reset
      && ($past(cyc_kind) == DXB_CYC_OTHER || $past(cyc_kind) == DXB_CYC_TABLE_WRITE_OP_SECOND))
    |-> program_address_lines == $past(cyc_pc))
    else $error("program address not driven");
  a_addr_held: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!$past(cyc_valid) && !core_in_reset) |-> $stable(program_address_lines))
    else $error("address moved without a request");
  a_port_out_sel: assert property (@(posedge clk_sys) disable iff (!nrst)
    ($past(cyc_valid) && $past(cyc_kind) == DXB_CYC_PORT_OUT && !core_in_reset)
    |-> program_address_lines[ADDR_W-1:PORT_W] == '0
      && program_address_lines[PORT_W-1:0] == $past(cyc_port))
    else $error("port number not on select lines for output");
  a_in_strobe_kind: assert property (@(posedge clk_sys) disable iff (!nrst)
    !input_strobe_n |-> $past(cyc_valid) && $past(cyc_kind) == DXB_CYC_PORT_IN)
    else $error("input strobe without a port input cycle");
  a_wr_strobe_kind: assert property (@(posedge clk_sys) disable iff (!nrst)
    !write_strobe_n |-> $past(cyc_valid)
      && ($past(cyc_kind) == DXB_CYC_PORT_OUT || $past(cyc_kind) == DXB_CYC_TABLE_WRITE_OP_SECOND))
    else $error("write strobe without an output cycle");
  a_wr_data_out: assert property (@(posedge clk_sys) disable iff (!nrst)
    !write_strobe_n |-> parallel_data_lines_o == $past(cyc_wdata))
    else $error("write data not on the data lines");
  a_in_data_core: assert property (@(posedge clk_sys) disable iff (!nrst)
    !$past(input_strobe_n, 3) |-> core_rdata == $past(parallel_data_lines_i, 3))
    else $error("input word not handed to the core");

endmodule : dxb_bus_pins

/* testbench/dxb_io_partner.sv */
module dxb_io_partner
  import dxb_pkg::*;
#(
  parameter logic [15:0] IN_WORD = 16'h5a3c
) (
  // clock and strobe
  input wire logic clk_sys,
  input wire logic input_strobe_n,
  // word offered toward the device
  output logic [DATA_W-1:0] drive_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cnt_q = 16'h0000;

  always_ff @(posedge clk_sys) begin
    cnt_q <= cnt_q + 16'h0001;
  end

  // off the strobe the lines show a changing pattern, not the word
  assign drive_data = !input_strobe_n ? IN_WORD : ~IN_WORD ^ cnt_q;
endmodule : dxb_io_partner

/* testbench/tb_dxb_bus_pins.sv */
module tb_dxb_bus_pins
  import dxb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, nrst, cyc_valid, core_in_reset;
  logic input_strobe_n, write_strobe_n, fetch_strobe_n;
  dxb_cycle_type cyc_kind;
  logic [11:0] cyc_pc, address;
  logic [2:0] cyc_port;
  logic [15:0] cyc_wdata, core_rdata, data_o, oe_n, pins_i, drv;
  int err_total = 0;
  int n_compared = 0;

  dxb_bus_pins dut (.clk_sys(clk_sys), .nrst(nrst), .cyc_valid(cyc_valid),
    .cyc_kind(cyc_kind), .cyc_pc(cyc_pc), .cyc_port(cyc_port), .cyc_wdata(cyc_wdata),
    .core_rdata(core_rdata), .core_in_reset(core_in_reset),
    .program_address_lines(address), .parallel_data_lines_o(data_o),
    .parallel_data_lines_oe_n(oe_n), .parallel_data_lines_i(pins_i),
    .input_strobe_n(input_strobe_n), .write_strobe_n(write_strobe_n),
    .fetch_strobe_n(fetch_strobe_n));
  dxb_io_partner io (.clk_sys(clk_sys), .input_strobe_n(input_strobe_n), .drive_data(drv));
  assign pins_i = (data_o & ~oe_n) | (drv & oe_n);

  // ----
  // checks and bus cycles
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_strb(input logic [2:0] exp);
    chk({13'h0, input_strobe_n, write_strobe_n, fetch_strobe_n}, {13'h0, exp});
  endtask : chk_strb

  task automatic issue(dxb_cycle_type k, logic [11:0] pc, logic [2:0] p, logic [15:0] w);
    cyc_valid = 1'b1;
    cyc_kind = k;
    cyc_pc = pc;
    cyc_port = p;
    cyc_wdata = w;
    @(negedge clk_sys);
  endtask : issue

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // ----
  // scenarios
  // ----
  task automatic do_reset;
    int i;
    nrst = 1'b0;
    #1;
    chk_strb(3'h7);
    chk(oe_n, 16'hffff);
    repeat (6) @(negedge clk_sys);
    chk({4'h0, address}, 16'h0000);
    // a request offered during the hold must be dropped
    cyc_valid = 1'b1;
    cyc_kind = DXB_CYC_PORT_OUT;
    cyc_port = 3'h5;
    nrst = 1'b1;
    for (i = 0; i < 20 && core_in_reset !== 1'b0; i++) begin
      chk_strb(3'h7);
      @(negedge clk_sys);
    end
    chk({15'h0, core_in_reset}, 16'h0000);
    chk(16'(i), 16'(RESET_MIN_CYCLES + 1));
    chk_strb(3'h5);
    chk({4'h0, address}, 16'h0005);
    cyc_valid = 1'b0;
    @(negedge clk_sys);
    chk_strb(3'h6);
    $display("reset test done");
  endtask : do_reset

  task automatic test_port_out;
    for (int p = 0; p < 8; p++) begin
      issue(DXB_CYC_PORT_OUT, 12'hfff, 3'(p), 16'h1357 * 16'(p + 1));
      chk({4'h0, address}, 16'(p));
      chk_strb(3'h5);
      chk(oe_n, 16'h0000);
      chk(data_o, 16'h1357 * 16'(p + 1));
    end
    $display("port output test done");
  endtask : test_port_out

  task automatic test_port_in;
    issue(DXB_CYC_PORT_IN, 12'hfff, 3'h6, 16'hffff);
    chk({4'h0, address}, 16'h0006);
    chk_strb(3'h3);
    chk(oe_n, 16'hffff);
    cyc_valid = 1'b0;
    repeat (5) @(negedge clk_sys);
    chk(core_rdata, 16'h5a3c);
    chk_strb(3'h6);
    $display("port input test done");
  endtask : test_port_in

  task automatic test_fetch;
    issue(DXB_CYC_FETCH, 12'h9a5, 3'h7, 16'h0000);
    chk({4'h0, address}, 16'h09a5);
    chk_strb(3'h6);
    issue(DXB_CYC_OTHER, 12'h35c, 3'h0, 16'h0000);
    chk({4'h0, address}, 16'h035c);
    chk_strb(3'h6);
    issue(DXB_CYC_TABLE_WRITE_OP_SECOND, 12'h0c3, 3'h0, 16'hbeef);
    chk({4'h0, address}, 16'h00c3);
    chk_strb(3'h5);
    chk(data_o, 16'hbeef);
    chk(oe_n, 16'h0000);
    issue(DXB_CYC_FETCH, 12'h7ff, 3'h0, 16'h0000);
    chk(oe_n, 16'hffff);
    chk_strb(3'h6);
    issue(DXB_CYC_PORT_OUT, 12'h123, 3'h3, 16'ha5a5);
    chk({4'h0, address}, 16'h0003);
    chk_strb(3'h5);
    chk(data_o, 16'ha5a5);
    $display("fetch test done");
  endtask : test_fetch

  // ----
  // clock, sequence and watchdog
  // ----
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial begin
    nrst = 1'b0;
    cyc_valid = 1'b0;
    cyc_kind = DXB_CYC_FETCH;
    cyc_pc = 12'h000;
    cyc_port = 3'h0;
    cyc_wdata = 16'h0000;
    @(negedge clk_sys);
    do_reset();
    test_port_out();
    test_port_in();
    test_fetch();
    do_reset();
    test_port_in();
    stop_test();
  end

  initial begin
    #100000;
    err_total++;
    stop_test();
  end
endmodule : tb_dxb_bus_pins
